// ==== design/hbridge_seq_pkg.sv ====
// Constants, register map and state encoding for the H-bridge sequencer
package hbridge_seq_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ                = 20;
    localparam int POWERUP_FLAG_TIME_NS   = 1000;    // Least hold of the flag at power-up
    localparam int TURN_ON_TIME_NS        = 1000000; // Longest wake-to-flag-release time
    localparam int POWERDOWN_DELAY_NS     = 8000;    // Least delay before power-down
    localparam int WAKE_PULSE_MIN_NS      = 1000;    // Least low pulse that clears faults
    localparam int CHOP_OFF_TIME_NS       = 10000;   // High-side off time per chop
    localparam int CNT_W                  = 16;

    localparam logic [CNT_W-1:0] POWERUP_FLAG_CYC =
        CNT_W'((POWERUP_FLAG_TIME_NS * CLK_MHZ + 999) / 1000);
    localparam logic [CNT_W-1:0] TURN_ON_CYC =
        CNT_W'((TURN_ON_TIME_NS / 1000) * CLK_MHZ);
    localparam logic [CNT_W-1:0] POWERDOWN_DELAY_CYC =
        CNT_W'((POWERDOWN_DELAY_NS * CLK_MHZ + 999) / 1000);
    localparam logic [CNT_W-1:0] WAKE_PULSE_MIN_CYC =
        CNT_W'((WAKE_PULSE_MIN_NS * CLK_MHZ + 999) / 1000);
    localparam logic [CNT_W-1:0] CHOP_OFF_CYC =
        CNT_W'((CHOP_OFF_TIME_NS * CLK_MHZ + 999) / 1000);
    localparam logic [CNT_W-1:0] CHOP_OFF_HOT_CYC = CNT_W'(2 * CHOP_OFF_CYC);

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_STATUS  = 8'h04;
    localparam logic [7:0] ADDR_STATE   = 8'h08;

    // Control fields
    localparam int CTL_OUT_EN = 0;
    localparam int CTL_SER_A  = 1;
    localparam int CTL_SER_B  = 2;
    localparam int CTL_HALF   = 3;
    localparam int CTL_SLEW_L = 4;
    localparam int CTL_LIM_L  = 8;
    localparam logic [31:0] CONTROL_MASK  = 32'h0000_037f;
    // Out enabled, 2.0 V/us slew (code 3), 7.0 A limit (code 1)
    localparam logic [31:0] CONTROL_RESET = 32'h0000_0131;

    // Status fields, sticky
    localparam int ST_OVERTEMP  = 0;
    localparam int ST_THERMWARN = 1;
    localparam int ST_OVERCUR   = 2;
    localparam int ST_OVERVOLT  = 3;
    localparam int ST_UNDERVOLT = 4;
    localparam int ST_PUMPLOW   = 5;
    localparam int ST_W         = 6;
    localparam logic [ST_W-1:0] FAULT_BITS = 6'h3d;

    // ------------------------------------------------------------
    // Operating states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_SLEEP   = 3'b000,
        ST_PWRUP   = 3'b001,
        ST_STANDBY = 3'b010,
        ST_NORMAL  = 3'b011,
        ST_FAULT   = 3'b100,
        ST_PWRDN   = 3'b101
    } opstate_t;

endpackage

// ==== design/hbridge_mode_fault_sequencer.sv ====
// Operating-state, fault-flag and protection sequencer for an H-bridge driver
//
// How it works
// - Six states: sleep, power-up, standby with outputs off, normal, fault, and power-down.
// - Any fault detected while running moves the block to the fault state.
// - Fault state forces outputs off, except the overvoltage brake, and holds the fault flag low.
// - Wake on enable rising edge; regulators start only if supply is good.
// - Flag low once supplies valid, at least 1.0 us, until pump good, no faults.
// - Flag returns high within 1.0 ms of wake, else fault.
// - Enable low turns both legs off at once and drives the flag low.
// - Power-down starts at least 8.0 us after enable falls; flag held meanwhile.
// - Flag releases at power-down only while the disable input is low.
// - Flag stays low until internal supplies are off.
// - Any transistor overcurrent shuts the bridge down immediately.
// - Load at limit chops the high side; four selectable limit levels.
// - Thermal warning sets a readable status bit.
// - Thermal warning doubles chop off time, lowering chop frequency.
// - Overtemperature on any transistor disables the outputs.
// - Legs follow enable, disable and direction pins with serial equivalents.
// - Eight serial slew-rate steps.
// - Defaults: 2.0 V/us slew, 7.0 A limit.
// - Serial mode bit picks full H-bridge or half-bridge.
// - Overvoltage in H-bridge mode brakes on both high sides and reports.
// - Short, overtemperature or undervoltage reports and disables outputs.
// - Enable rising after a low pulse of 1.0 us clears inactive faults.
//
// The implementer's own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps

module hbridge_mode_fault_sequencer #(
    parameter logic [15:0] TURN_ON_CYC = hbridge_seq_pkg::TURN_ON_CYC
) (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        wakeEnableInput,
    input  wire logic        outputOffInput,
    input  wire logic        bridgeCtlA,
    input  wire logic        bridgeCtlB,
    input  wire logic        mainSupplyOk,
    input  wire logic        suppliesValid,
    input  wire logic        pumpAboveLow,
    input  wire logic [3:0]  overCurrent,
    input  wire logic [3:0]  overTemp,
    input  wire logic        thermalWarn,
    input  wire logic        overVoltage,
    input  wire logic        underVoltage,
    input  wire logic        limitReached,
    input  wire logic        faultFlagNIn,
    output logic             faultFlagNOut,
    output logic             faultFlagNOe,
    output logic             regulatorOn,
    output logic             legAHighOn,
    output logic             legALowOn,
    output logic             legBHighOn,
    output logic             legBLowOn,
    output logic      [2:0]  slewSel,
    output logic      [1:0]  limitSel
);

    localparam int CW = hbridge_seq_pkg::CNT_W;
    localparam int SW = hbridge_seq_pkg::ST_W;

    hbridge_seq_pkg::opstate_t state_ff;
    hbridge_seq_pkg::opstate_t nxt_state;

    logic [31:0]   control_ff;
    logic [SW-1:0] status_ff;
    logic [CW-1:0] timer_ff;
    logic [CW-1:0] flagCnt_ff;
    logic [CW-1:0] lowCnt_ff;
    logic [CW-1:0] chopCnt_ff;
    logic [31:0]   prdata_ff;
    logic          wakePrev_ff;
    logic          flagLow_ff;
    logic          regOn_ff;
    logic          legAHigh_ff;
    logic          legALow_ff;
    logic          legBHigh_ff;
    logic          legBLow_ff;

    logic          wakeRise;
    logic          wakeClear;
    logic          anyOverCur;
    logic          anyOverTemp;
    logic          pumpLow;
    logic [SW-1:0] activeFaults;
    logic [SW-1:0] swClear;
    logic          faultLatched;
    logic          drivesOn;
    logic          halfMode;
    logic          ctlA;
    logic          ctlB;
    logic          chopping;
    logic          flagHoldDone;
    logic          pdDelayDone;
    logic          apbSetup;
    logic          apbWrite;
    logic          addrHit;

    // ------------------------------------------------------------
    // Event detection
    // ------------------------------------------------------------
    assign wakeRise    = wakeEnableInput & ~wakePrev_ff;
    assign wakeClear   = wakeRise & (lowCnt_ff >= hbridge_seq_pkg::WAKE_PULSE_MIN_CYC);
    assign anyOverCur  = |overCurrent;
    assign anyOverTemp = |overTemp;
    // Pump only counts once running, so start-up does not trip it
    assign pumpLow     = ~pumpAboveLow & (state_ff == hbridge_seq_pkg::ST_STANDBY
                                        || state_ff == hbridge_seq_pkg::ST_NORMAL);

    always_comb begin
        activeFaults = '0;
        activeFaults[hbridge_seq_pkg::ST_OVERTEMP]  = anyOverTemp;
        activeFaults[hbridge_seq_pkg::ST_THERMWARN] = thermalWarn;
        activeFaults[hbridge_seq_pkg::ST_OVERCUR]   = anyOverCur;
        activeFaults[hbridge_seq_pkg::ST_OVERVOLT]  = overVoltage;
        activeFaults[hbridge_seq_pkg::ST_UNDERVOLT] = underVoltage;
        activeFaults[hbridge_seq_pkg::ST_PUMPLOW]   = pumpLow;
    end

    assign faultLatched = |(status_ff & hbridge_seq_pkg::FAULT_BITS);
    assign halfMode     = control_ff[hbridge_seq_pkg::CTL_HALF];
    assign ctlA         = bridgeCtlA | control_ff[hbridge_seq_pkg::CTL_SER_A];
    assign ctlB         = bridgeCtlB | control_ff[hbridge_seq_pkg::CTL_SER_B];
    assign drivesOn     = wakeEnableInput & ~outputOffInput
                        & control_ff[hbridge_seq_pkg::CTL_OUT_EN];
    assign chopping     = chopCnt_ff != '0;
    assign flagHoldDone = flagCnt_ff >= hbridge_seq_pkg::POWERUP_FLAG_CYC;
    assign pdDelayDone  = timer_ff >= hbridge_seq_pkg::POWERDOWN_DELAY_CYC;

    // ------------------------------------------------------------
    // APB slave, zero wait states
    // ------------------------------------------------------------
    assign apbSetup = psel & ~penable;
    assign apbWrite = psel & penable & pwrite;
    assign addrHit  = paddr == hbridge_seq_pkg::ADDR_CONTROL
                   || paddr == hbridge_seq_pkg::ADDR_STATUS
                   || paddr == hbridge_seq_pkg::ADDR_STATE;
    assign pready   = psel & penable;
    assign pslverr  = psel & penable & ~addrHit;
    assign prdata   = prdata_ff;
    assign swClear  = (apbWrite && paddr == hbridge_seq_pkg::ADDR_STATUS)
                    ? pwdata[SW-1:0] : '0;

    // Read data is captured in the setup cycle so it comes from a flop
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            prdata_ff <= '0;
        end else if (apbSetup) begin
            case (paddr)
                hbridge_seq_pkg::ADDR_CONTROL: prdata_ff <= control_ff;
                hbridge_seq_pkg::ADDR_STATUS:  prdata_ff <= {{(32-SW){1'b0}}, status_ff};
                hbridge_seq_pkg::ADDR_STATE:   prdata_ff <= {24'h000000, wakeEnableInput,
                                                  faultFlagNIn, flagLow_ff, regOn_ff,
                                                  1'b0, state_ff};
                default:                       prdata_ff <= '0;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            control_ff <= hbridge_seq_pkg::CONTROL_RESET;
        end else if (apbWrite && paddr == hbridge_seq_pkg::ADDR_CONTROL) begin
            control_ff <= pwdata & hbridge_seq_pkg::CONTROL_MASK;
        end
    end

    assign slewSel  = control_ff[hbridge_seq_pkg::CTL_SLEW_L +: 3];
    assign limitSel = control_ff[hbridge_seq_pkg::CTL_LIM_L +: 2];

    // ------------------------------------------------------------
    // Sticky status: a present fault always wins over a clear
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            status_ff <= '0;
        end else if (wakeClear) begin
            status_ff <= activeFaults;
        end else begin
            status_ff <= (status_ff & ~swClear) | activeFaults;
        end
    end

    // ------------------------------------------------------------
    // Enable edge and low-pulse width
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wakePrev_ff <= 1'b0;
        end else begin
            wakePrev_ff <= wakeEnableInput;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            lowCnt_ff <= '0;
        end else if (wakeEnableInput) begin
            lowCnt_ff <= '0;
        end else if (lowCnt_ff < hbridge_seq_pkg::WAKE_PULSE_MIN_CYC) begin
            lowCnt_ff <= lowCnt_ff + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Operating state machine
    // ------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            hbridge_seq_pkg::ST_SLEEP: begin
                if (wakeRise && mainSupplyOk) begin
                    nxt_state = hbridge_seq_pkg::ST_PWRUP;
                end
            end
            hbridge_seq_pkg::ST_PWRUP: begin
                if (!wakeEnableInput) begin
                    nxt_state = hbridge_seq_pkg::ST_PWRDN;
                end else if (flagHoldDone && pumpAboveLow && !faultLatched) begin
                    nxt_state = hbridge_seq_pkg::ST_STANDBY;
                end else if (timer_ff >= TURN_ON_CYC) begin
                    nxt_state = hbridge_seq_pkg::ST_FAULT;
                end
            end
            hbridge_seq_pkg::ST_STANDBY, hbridge_seq_pkg::ST_NORMAL: begin
                if (!wakeEnableInput) begin
                    nxt_state = hbridge_seq_pkg::ST_PWRDN;
                end else if (faultLatched) begin
                    nxt_state = hbridge_seq_pkg::ST_FAULT;
                end else if (drivesOn) begin
                    nxt_state = hbridge_seq_pkg::ST_NORMAL;
                end else begin
                    nxt_state = hbridge_seq_pkg::ST_STANDBY;
                end
            end
            hbridge_seq_pkg::ST_FAULT: begin
                if (!wakeEnableInput) begin
                    nxt_state = hbridge_seq_pkg::ST_PWRDN;
                end else if (!faultLatched && pumpAboveLow) begin
                    nxt_state = hbridge_seq_pkg::ST_STANDBY;
                end
            end
            hbridge_seq_pkg::ST_PWRDN: begin
                if (wakeRise && mainSupplyOk) begin
                    nxt_state = hbridge_seq_pkg::ST_PWRUP;
                end else if (pdDelayDone && !suppliesValid && !outputOffInput) begin
                    nxt_state = hbridge_seq_pkg::ST_SLEEP;
                end
            end
            default: nxt_state = hbridge_seq_pkg::ST_SLEEP;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_ff <= hbridge_seq_pkg::ST_SLEEP;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Time spent in the current state; wraps are avoided by saturation
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            timer_ff <= '0;
        end else if (nxt_state != state_ff) begin
            timer_ff <= '0;
        end else if (timer_ff != '1) begin
            timer_ff <= timer_ff + 1'b1;
        end
    end

    // Flag hold time counts only once internal supplies are valid
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            flagCnt_ff <= '0;
        end else if (state_ff != hbridge_seq_pkg::ST_PWRUP || !suppliesValid) begin
            flagCnt_ff <= '0;
        end else if (!flagHoldDone) begin
            flagCnt_ff <= flagCnt_ff + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Regulators and fault flag
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            regOn_ff <= 1'b0;
        end else if (nxt_state == hbridge_seq_pkg::ST_PWRUP) begin
            regOn_ff <= 1'b1;
        end else if (state_ff == hbridge_seq_pkg::ST_PWRDN && pdDelayDone) begin
            regOn_ff <= 1'b0;
        end
    end

    // Flag is low in power-up once supplies are valid, through fault and the whole power-down
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            flagLow_ff <= 1'b0;
        end else begin
            case (nxt_state)
                hbridge_seq_pkg::ST_PWRUP:   flagLow_ff <= suppliesValid;
                hbridge_seq_pkg::ST_FAULT:   flagLow_ff <= 1'b1;
                hbridge_seq_pkg::ST_PWRDN:   flagLow_ff <= 1'b1;
                default:                     flagLow_ff <= 1'b0;
            endcase
        end
    end

    assign faultFlagNOut = 1'b0;
    assign faultFlagNOe  = flagLow_ff;
    assign regulatorOn   = regOn_ff;

    // ------------------------------------------------------------
    // Current-limit chopping
    // ------------------------------------------------------------
    // A hot die doubles the off time; the limit itself is unchanged
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            chopCnt_ff <= '0;
        end else if (state_ff != hbridge_seq_pkg::ST_NORMAL) begin
            chopCnt_ff <= '0;
        end else if (chopping) begin
            chopCnt_ff <= chopCnt_ff - 1'b1;
        end else if (limitReached) begin
            chopCnt_ff <= thermalWarn ? hbridge_seq_pkg::CHOP_OFF_HOT_CYC
                                      : hbridge_seq_pkg::CHOP_OFF_CYC;
        end
    end

    // ------------------------------------------------------------
    // Bridge leg drive
    // ------------------------------------------------------------
    // Direct fault inputs also gate the legs so shutdown needs no extra cycle
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            legAHigh_ff <= 1'b0;
            legALow_ff  <= 1'b0;
            legBHigh_ff <= 1'b0;
            legBLow_ff  <= 1'b0;
        end else if (!wakeEnableInput || anyOverCur || anyOverTemp || underVoltage) begin
            legAHigh_ff <= 1'b0;
            legALow_ff  <= 1'b0;
            legBHigh_ff <= 1'b0;
            legBLow_ff  <= 1'b0;
        end else if (overVoltage && !halfMode) begin
            legAHigh_ff <= 1'b1;
            legALow_ff  <= 1'b0;
            legBHigh_ff <= 1'b1;
            legBLow_ff  <= 1'b0;
        end else if (nxt_state == hbridge_seq_pkg::ST_NORMAL) begin
            legAHigh_ff <= ctlA & ~chopping;
            legALow_ff  <= ~ctlA & ~halfMode;
            legBHigh_ff <= ctlB & ~chopping;
            legBLow_ff  <= ~ctlB & ~halfMode;
        end else begin
            legAHigh_ff <= 1'b0;
            legALow_ff  <= 1'b0;
            legBHigh_ff <= 1'b0;
            legBLow_ff  <= 1'b0;
        end
    end

    assign legAHighOn = legAHigh_ff;
    assign legALowOn  = legALow_ff;
    assign legBHighOn = legBHigh_ff;
    assign legBLowOn  = legBLow_ff;

endmodule

// ==== testbench/host_flag_line.sv ====
// Open-drain fault flag line with its pull-up, as the host sees it
`timescale 1ns/10ps
module host_flag_line (
    input  wire logic faultFlagNOut,
    input  wire logic faultFlagNOe,
    output logic      faultFlagNIn
);
    // A released line floats up to the pull-up, never to the last driven level
    assign faultFlagNIn = faultFlagNOe ? faultFlagNOut : 1'b1;
endmodule

// ==== testbench/hbridge_seq_props.sv ====
// Concurrent checks on the sequencer's pins
`timescale 1ns/10ps
module hbridge_seq_props #(
    parameter logic [15:0] TURN_ON_CYC = 16'd20000
) (
    input wire logic       clk,
    input wire logic       rst_b,
    input wire logic       wakeEnableInput,
    input wire logic       outputOffInput,
    input wire logic       mainSupplyOk,
    input wire logic       suppliesValid,
    input wire logic [3:0] overCurrent,
    input wire logic [3:0] overTemp,
    input wire logic       underVoltage,
    input wire logic       faultFlagNOe,
    input wire logic       regulatorOn,
    input wire logic       legAHighOn,
    input wire logic       legALowOn,
    input wire logic       legBHighOn,
    input wire logic       legBLowOn
);
    logic [7:0] lowCnt_ff;
    logic       legsOff;
    assign legsOff = !(legAHighOn | legALowOn | legBHighOn | legBLowOn);
    // Saturating run length of enable low
    always_ff @(posedge clk) begin
        if (!rst_b || wakeEnableInput) begin
            lowCnt_ff <= 8'h00;
        end else if (lowCnt_ff != 8'hff) begin
            lowCnt_ff <= lowCnt_ff + 8'h01;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    // Only an awake device owes a low flag; a refused wake pulse leaves it released
    sequence wakeLost; $fell(wakeEnableInput) && regulatorOn; endsequence
    sequence flagFreed; $fell(faultFlagNOe) && !wakeEnableInput; endsequence
    legs_off_low_a: assert property (!wakeEnableInput |=> legsOff)
        else $error("legs on while enable low");
    flag_on_drop_a: assert property (wakeLost |=> faultFlagNOe)
        else $error("flag not low after enable fell");
    pd_delay_a: assert property (flagFreed |-> lowCnt_ff >= 8'd160)
        else $error("flag freed before power-down delay");
    pd_dis_a: assert property (flagFreed |-> !$past(outputOffInput))
        else $error("flag freed with disable high");
    pd_supply_a: assert property (flagFreed |-> !$past(suppliesValid) && !regulatorOn)
        else $error("flag freed with supplies on");
    fault_kill_a: assert property ((|overCurrent || |overTemp || underVoltage) |=> legsOff)
        else $error("legs on during fault");
    wake_start_a: assert property ($rose(wakeEnableInput) && mainSupplyOk && !regulatorOn
        && !faultFlagNOe |=> regulatorOn) else $error("no start on wake");
    wake_refuse_a: assert property ($rose(wakeEnableInput) && !mainSupplyOk && !regulatorOn
        |=> !regulatorOn) else $error("start with supply low");
endmodule
bind hbridge_mode_fault_sequencer hbridge_seq_props #(.TURN_ON_CYC(TURN_ON_CYC)) props_inst (
    .clk(clk), .rst_b(rst_b), .wakeEnableInput(wakeEnableInput), .outputOffInput(outputOffInput),
    .mainSupplyOk(mainSupplyOk), .suppliesValid(suppliesValid), .overCurrent(overCurrent),
    .overTemp(overTemp), .underVoltage(underVoltage), .faultFlagNOe(faultFlagNOe),
    .regulatorOn(regulatorOn), .legAHighOn(legAHighOn), .legALowOn(legALowOn),
    .legBHighOn(legBHighOn), .legBLowOn(legBLowOn));

// ==== testbench/hbridge_mode_fault_sequencer_tb.sv ====
// Self-checking bench for the H-bridge mode and fault sequencer
`timescale 1ns/10ps
module hbridge_mode_fault_sequencer_tb;
    localparam logic [15:0] TON = 16'd200;
    logic        clk, rst_b, psel, penable, pwrite, pready, err, wake, off, ctlA, supOk;
    logic        supV, uv, ov, flagIn, flagOut, flagOe, regOn, aH, aL, bH, bL, lr, tw, apbErr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd, ctlModel;
    logic [3:0]  oc, ot;
    logic [2:0]  slew;
    logic [1:0]  lim;
    logic [3:0]  legExp [4] = '{4'h0, 4'h0, 4'h0, 4'ha};
    int          stBit [4] = '{2, 0, 4, 3};
    integer      n_mismatch, checked, seed, i, k;
    hbridge_mode_fault_sequencer #(.TURN_ON_CYC(TON)) hbridge_mode_fault_sequencer_inst (
        .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(err),
        .wakeEnableInput(wake), .outputOffInput(off), .bridgeCtlA(ctlA), .bridgeCtlB(1'b0),
        .mainSupplyOk(supOk), .suppliesValid(supV), .pumpAboveLow(1'b1), .overCurrent(oc),
        .overTemp(ot), .thermalWarn(tw), .overVoltage(ov), .underVoltage(uv),
        .limitReached(lr), .faultFlagNIn(flagIn), .faultFlagNOut(flagOut),
        .faultFlagNOe(flagOe), .regulatorOn(regOn), .legAHighOn(aH), .legALowOn(aL),
        .legBHighOn(bH), .legBLowOn(bL), .slewSel(slew), .limitSel(lim));
    host_flag_line host_flag_line_inst (.faultFlagNOut(flagOut), .faultFlagNOe(flagOe),
        .faultFlagNIn(flagIn));
    // Internal supplies settle one cycle after the regulator switches
    always @(posedge clk) supV <= regOn;
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        apbErr = err;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wrap_up;
        $display("checked %0d, n_mismatch %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        #500000;
        n_mismatch++;
        wrap_up;
    end
    initial begin
        seed = 32'hbe5fe172;
        n_mismatch = 0;
        checked = 0;
        ctlModel = hbridge_seq_pkg::CONTROL_RESET;
        {psel, penable, pwrite, wake, off, ctlA, supOk, uv, ov, supV, lr, tw, rst_b} = '0;
        {paddr, pwdata, oc, ot} = '0;
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        apb(1'b0, hbridge_seq_pkg::ADDR_CONTROL, 32'h0);
        chk(rd, ctlModel);
        apb(1'b0, 8'h0c, 32'h0);
        chk({apbErr, rd[30:0]}, 32'h8000_0000);
        ctlModel = (ctlModel & ~32'h370) | ((32'($random(seed)) & 32'h37) << 4);
        apb(1'b1, hbridge_seq_pkg::ADDR_CONTROL, ctlModel);
        apb(1'b0, hbridge_seq_pkg::ADDR_CONTROL, 32'h0);
        chk(rd, ctlModel);
        chk(slew, ctlModel[6:4]);
        chk(lim, ctlModel[9:8]);
        $display("register test ended");
        @(posedge clk) wake <= 1'b1;
        tick(10);
        chk(regOn, 1'b0);
        @(posedge clk) wake <= 1'b0;
        tick(250);
        @(posedge clk) supOk <= 1'b1;
        wake <= 1'b1;
        for (i = 0; i < 1000 && flagIn !== 1'b0; i++) tick(1);
        for (i = i; i < 1000 && flagIn !== 1'b1; i++) tick(1);
        chk(i >= 20 && i <= TON, 1'b1);
        tick(3);
        apb(1'b0, hbridge_seq_pkg::ADDR_STATE, 32'h0);
        chk(rd[2:0], 3'h3);
        @(posedge clk) ctlA <= 1'b1;
        tick(2);
        chk({aH, aL, bH, bL}, 4'b1001);
        $display("power-up test ended");
        // One limit hit per pass; a hot die must keep the high side off twice as long
        for (k = 0; k < 2; k++) begin
            @(posedge clk) lr <= 1'b1;
            tw <= k[0];
            @(posedge clk) lr <= 1'b0;
            tick(100);
            chk(aH, 1'b0);
            tick(200);
            chk(aH, k == 0);
            tick(150);
        end
        apb(1'b0, hbridge_seq_pkg::ADDR_STATUS, 32'h0);
        chk(rd[1], 1'b1);
        tw <= 1'b0;
        apb(1'b1, hbridge_seq_pkg::ADDR_CONTROL, ctlModel | 32'h8);
        tick(2);
        chk({aH, aL, bH, bL}, 4'b1000);
        apb(1'b1, hbridge_seq_pkg::ADDR_CONTROL, ctlModel);
        $display("chop and mode test ended");
        for (k = 0; k < 4; k++) begin
            @(posedge clk);
            case (k)
                0: oc <= 4'(4'h1 << (32'($random(seed)) & 32'h3));
                1: ot <= 4'(4'h1 << (32'($random(seed)) & 32'h3));
                2: uv <= 1'b1;
                default: ov <= 1'b1;
            endcase
            tick(30);
            chk({aH, aL, bH, bL}, legExp[k]);
            chk(flagIn, 1'b0);
            apb(1'b0, hbridge_seq_pkg::ADDR_STATE, 32'h0);
            chk(rd[2:0], 3'h4);
            {oc, ot, uv, ov} <= '0;
            apb(1'b0, hbridge_seq_pkg::ADDR_STATUS, 32'h0);
            chk(rd[stBit[k]], 1'b1);
            apb(1'b1, hbridge_seq_pkg::ADDR_STATUS, 32'h3f);
            for (i = 0; i < 100 && flagIn !== 1'b1; i++) tick(1);
            tick(3);
            apb(1'b0, hbridge_seq_pkg::ADDR_STATE, 32'h0);
            chk(rd[2:0], 3'h3);
        end
        $display("fault test ended");
        @(posedge clk) off <= 1'b1;
        wake <= 1'b0;
        tick(1);
        chk({aH, aL, bH, bL, flagIn}, 5'h0);
        for (i = 1; i < 400 && regOn !== 1'b0; i++) tick(1);
        chk(i >= 160 && i <= 220, 1'b1);
        tick(40);
        chk(flagIn, 1'b0);
        @(posedge clk) off <= 1'b0;
        for (i = 0; i < 20 && flagIn !== 1'b1; i++) tick(1);
        apb(1'b0, hbridge_seq_pkg::ADDR_STATE, 32'h0);
        chk({flagIn, rd[2:0]}, 4'h8);
        $display("power-down test ended");
        wrap_up;
    end
endmodule
